// ### logic/dcsp_top.sv
// serial control port of a two-channel device: chained channels, register and ram access
// assumes the serial clock samples on its rising edge and the core services ram at slot pulses

// Notes on behaviour
// - control byte: broadcast, read, register, channel
// - control, address, data bytes, msb first
// - chip select mid-byte returns to idle
// - broadcast honoured for writes only
// - forwarded channel field decremented lsb first
// - two channels chained inside each device
// - channel seeing zero executes the access
// - broadcast, read, register bits pass unchanged
// - broadcast passes every bit unchanged
// - input ignored during read data
// - select kept low means eight more clocks
// - second write byte is discarded
// - register read value sent twice
// - register read loaded after address byte
// - register write after data byte completes
// - ram accesses always take four bytes
// - ram read returns previous request's data
// - ram read logs address and pending request
// - ram write logs address, data, pending
// - pending served at slots, status visible
// - per-channel done pulse after service
// - buffers and status kept per channel
module dcsp_top (
  // system clock and reset
  input  wire logic                                        clk_sys,
  input  wire logic                                        srst,
  // serial link
  input  wire logic                                        spi_sclk,
  input  wire logic                                        spi_cs_n,
  input  wire logic                                        spi_sdi,
  output logic                                             spi_sdo,
  output logic                                             spi_sdo_oe,
  output logic                                             chain_data_out,
  // ram service towards the core
  input  wire logic                                        ram_slot,
  output dcsp_pkg::dcsp_ram_req_t [dcsp_pkg::NCH-1:0]      ram_req,
  input  wire logic [dcsp_pkg::NCH-1:0][dcsp_pkg::RAM_W-1:0] ram_rdata,
  output logic [dcsp_pkg::NCH-1:0]                         ram_request_pending,
  output logic [dcsp_pkg::NCH-1:0]                         ram_done,
  // register writes towards the core
  output dcsp_pkg::dcsp_reg_wr_t [dcsp_pkg::NCH-1:0]       reg_wr
);

  localparam int NCH = dcsp_pkg::NCH;

  // a rise after chip select went high abandons the operation unless it lands on a byte boundary mid-access
  function automatic logic ends_op(input logic gap_seen, input logic [2:0] cnt, input dcsp_pkg::dcsp_phase_t phase);
    return gap_seen && (cnt != dcsp_pkg::BIT_FIRST || phase == dcsp_pkg::PH_MORE);
  endfunction

  dcsp_pkg::dcsp_link_t          lq, ld;
  dcsp_pkg::dcsp_sys_t           sq, sd;
  logic                          gap_w;
  logic [NCH:0]                  chain_w;
  logic [NCH-1:0]                we_w;
  logic [NCH-1:0][dcsp_pkg::ADDR_W-1:0] wa_w;
  logic [NCH-1:0][dcsp_pkg::REG_W-1:0]  wd_w;
  logic [NCH-1:0]                reg_pulse_w;
  logic [NCH-1:0]                ram_pulse_w;
  logic [dcsp_pkg::REG_W-1:0]    reg_mem [NCH][dcsp_pkg::NREG];

  // chip select rising is caught asynchronously, since the serial clock stops between bytes
  dcsp_gap u_gap (
    .spi_sclk (spi_sclk),
    .spi_cs_n (spi_cs_n),
    .gap_q    (gap_w)
  );

  // link domain: both channels, channel 0 nearest the controller
  always_comb begin
    dcsp_pkg::dcsp_phase_t      ph;
    logic [2:0]                 bc;
    logic                       din;
    logic                       tgt;
    logic [dcsp_pkg::ADDR_W-1:0] a;
    logic [dcsp_pkg::RAM_W-1:0] full;
    ph         = dcsp_pkg::PH_CTRL;
    bc         = dcsp_pkg::BIT_FIRST;
    din        = 1'b0;
    tgt        = 1'b0;
    a          = '0;
    full       = '0;
    ld         = lq;
    // reset reaches the link through two serial clock flops, so the serial clock must run while it is held
    ld.rst_meta = srst;
    ld.rst_sync = lq.rst_meta;
    chain_w    = '0;
    chain_w[0] = spi_sdi;
    we_w       = '0;
    wa_w       = '0;
    wd_w       = '0;
    for (int c = 0; c < NCH; c++) begin
      din = chain_w[c];
      ph  = lq.ch[c].phase;
      bc  = lq.ch[c].bitcnt;
      if (ends_op(gap_w, bc, ph)) begin
        ph = dcsp_pkg::PH_CTRL;
        bc = dcsp_pkg::BIT_FIRST;
      end else if (ph == dcsp_pkg::PH_MORE) begin
        ph = dcsp_pkg::PH_DATA2;
      end
      // forwarding towards the next channel
      chain_w[c+1] = din;
      if (ph == dcsp_pkg::PH_CTRL && bc >= dcsp_pkg::IDX_CID0 && !lq.ch[c].bcast) begin
        chain_w[c+1] = din ^ lq.ch[c].borrow;
      end
      // broadcast leaves the stream untouched; reads never execute on broadcast
      tgt = lq.ch[c].bcast ? !lq.ch[c].rd : lq.ch[c].cid_zero;
      if (!spi_cs_n) begin
        ld.ch[c].bitcnt = bc + dcsp_pkg::BIT_STEP;
        ld.ch[c].phase  = ph;
        case (ph)
          dcsp_pkg::PH_CTRL: begin
            if (bc == dcsp_pkg::IDX_BCAST) begin
              ld.ch[c].bcast    = din;
              ld.ch[c].borrow   = 1'b1;
              ld.ch[c].cid_zero = 1'b1;
              ld.ch[c].drive    = 1'b0;
            end
            if (bc == dcsp_pkg::IDX_READ) begin
              ld.ch[c].rd = din;
            end
            if (bc == dcsp_pkg::IDX_REG) begin
              ld.ch[c].isreg = din;
            end
            if (bc >= dcsp_pkg::IDX_CID0) begin
              ld.ch[c].borrow   = lq.ch[c].borrow & ~din;
              ld.ch[c].cid_zero = lq.ch[c].cid_zero & ~din;
            end
            if (bc == dcsp_pkg::BIT_LAST) begin
              ld.ch[c].phase = dcsp_pkg::PH_ADDR;
            end
          end
          dcsp_pkg::PH_ADDR: begin
            ld.ch[c].addr = {lq.ch[c].addr[dcsp_pkg::BYTE_BITS-2:0], din};
            // only the low seven address bits select a register
            a = {lq.ch[c].addr[dcsp_pkg::ADDR_W-2:0], din};
            if (bc == dcsp_pkg::BIT_LAST) begin
              ld.ch[c].phase = dcsp_pkg::PH_DATA;
              if (tgt && lq.ch[c].rd) begin
                ld.ch[c].drive = 1'b1;
                if (lq.ch[c].isreg) begin
                  ld.ch[c].tx = {reg_mem[c][a], reg_mem[c][a]};
                end else begin
                  ld.ch[c].tx = sq.ch[c].rd_buf;
                end
              end
            end
          end
          dcsp_pkg::PH_DATA, dcsp_pkg::PH_DATA2: begin
            // read data ignores the input line, it only fills the unused shifter
            ld.ch[c].data = {lq.ch[c].data[dcsp_pkg::RAM_W-2:0], din};
            full          = {lq.ch[c].data[dcsp_pkg::RAM_W-2:0], din};
            if (lq.ch[c].drive) begin
              ld.ch[c].tx = {lq.ch[c].tx[dcsp_pkg::RAM_W-2:0], 1'b0};
            end
            if (bc == dcsp_pkg::BIT_LAST && ph == dcsp_pkg::PH_DATA) begin
              if (lq.ch[c].isreg) begin
                ld.ch[c].phase = dcsp_pkg::PH_MORE;
                if (tgt && !lq.ch[c].rd) begin
                  we_w[c]           = 1'b1;
                  wa_w[c]           = lq.ch[c].addr[dcsp_pkg::ADDR_W-1:0];
                  wd_w[c]           = full[dcsp_pkg::REG_W-1:0];
                  ld.ch[c].reg_addr = lq.ch[c].addr[dcsp_pkg::ADDR_W-1:0];
                  ld.ch[c].reg_data = full[dcsp_pkg::REG_W-1:0];
                  ld.ch[c].reg_tgl  = ~lq.ch[c].reg_tgl;
                end
              end else begin
                ld.ch[c].phase = dcsp_pkg::PH_DATA2;
              end
            end
            if (bc == dcsp_pkg::BIT_LAST && ph == dcsp_pkg::PH_DATA2) begin
              ld.ch[c].phase = dcsp_pkg::PH_CTRL;
              ld.ch[c].drive = 1'b0;
              // second register byte is dropped here
              if (!lq.ch[c].isreg && tgt) begin
                ld.ch[c].ram_addr  = lq.ch[c].addr[dcsp_pkg::ADDR_W-1:0];
                ld.ch[c].ram_write = !lq.ch[c].rd;
                if (!lq.ch[c].rd) begin
                  ld.ch[c].ram_wdata = full;
                end
                ld.ch[c].ram_tgl = ~lq.ch[c].ram_tgl;
              end
            end
          end
          default: begin
            ld.ch[c].phase = dcsp_pkg::PH_CTRL;
          end
        endcase
      end
    end
    // channel state clears while the synchronised reset stands
    if (lq.rst_sync) begin
      ld.ch = '0;
    end
  end

  always_ff @(posedge spi_sclk) begin
    lq <= ld;
  end

  // per-channel register files
  // written on the serial clock so a later read in the same domain sees the new value
  always_ff @(posedge spi_sclk) begin
    for (int c = 0; c < NCH; c++) begin
      if (we_w[c]) begin
        reg_mem[c][wa_w[c]] <= wd_w[c];
      end
    end
  end

  // only the targeted channel drives, and never before a rise that abandons the operation,
  // so a stale shifter cannot reach the first control bit of the next frame
  always_comb begin
    spi_sdo    = 1'b0;
    spi_sdo_oe = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      if (lq.ch[c].drive && !spi_cs_n && !ends_op(gap_w, lq.ch[c].bitcnt, lq.ch[c].phase)) begin
        spi_sdo    = lq.ch[c].tx[dcsp_pkg::RAM_W-1];
        spi_sdo_oe = 1'b1;
      end
    end
  end

  // the stream leaves after the last channel, towards the next device in the chain
  assign chain_data_out = chain_w[NCH];

  // events into the system domain
  // each toggle carries one event; its payload fields are read only after the pulse
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_sync
      dcsp_tsync u_reg_sync (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .tgl_in    (lq.ch[g].reg_tgl),
        .pulse_out (reg_pulse_w[g])
      );
      dcsp_tsync u_ram_sync (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .tgl_in    (lq.ch[g].ram_tgl),
        .pulse_out (ram_pulse_w[g])
      );
    end
  endgenerate

  // system domain: register write strobes and ram servicing
  always_comb begin
    sd = sq;
    for (int c = 0; c < NCH; c++) begin
      sd.ch[c].req.valid = 1'b0;
      sd.ch[c].wr.valid  = 1'b0;
      sd.ch[c].done      = 1'b0;
      // holding fields are stable: they change only one toggle later
      if (reg_pulse_w[c]) begin
        sd.ch[c].wr.valid = 1'b1;
        sd.ch[c].wr.addr  = lq.ch[c].reg_addr;
        sd.ch[c].wr.data  = lq.ch[c].reg_data;
      end
      // the completing cycle ignores the slot; otherwise a slot launches a pending request
      if (sq.ch[c].req.valid) begin
        if (!sq.ch[c].req.write) begin
          sd.ch[c].rd_buf = ram_rdata[c];
        end
        sd.ch[c].pending = 1'b0;
        sd.ch[c].done    = 1'b1;
      end else if (ram_slot && sq.ch[c].pending) begin
        sd.ch[c].req.valid = 1'b1;
        sd.ch[c].req.write = lq.ch[c].ram_write;
        sd.ch[c].req.addr  = lq.ch[c].ram_addr;
        sd.ch[c].req.wdata = lq.ch[c].ram_wdata;
      end
      // a new request in the completing cycle stays pending
      if (ram_pulse_w[c]) begin
        sd.ch[c].pending = 1'b1;
      end
    end
    if (srst) begin
      sd = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    sq <= sd;
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ram_req[c]             = sq.ch[c].req;
      reg_wr[c]              = sq.ch[c].wr;
      ram_request_pending[c] = sq.ch[c].pending;
      ram_done[c]            = sq.ch[c].done;
    end
  end

endmodule // dcsp_top

// ### logic/dcsp_pkg.sv
// constants and carrier types for the daisy-chained serial control port
// assumes one device holds NCH channels chained on one serial link
package dcsp_pkg;

  localparam int NCH       = 2;
  localparam int ADDR_W    = 7;
  localparam int REG_W     = 8;
  localparam int RAM_W     = 16;
  localparam int NREG      = 128;
  localparam int BYTE_BITS = 8;

  // control byte bit positions as shifted in, msb first
  localparam int CTL_BCAST = 7;
  localparam int CTL_READ  = 6;
  localparam int CTL_REG   = 5;

  // arrival index within the control byte
  localparam logic [2:0] IDX_BCAST = 3'h0;
  localparam logic [2:0] IDX_READ  = 3'h1;
  localparam logic [2:0] IDX_REG   = 3'h2;
  localparam logic [2:0] IDX_CID0  = 3'h4;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [2:0] BIT_STEP  = 3'h1;

  typedef enum logic [2:0] {
    PH_CTRL,
    PH_ADDR,
    PH_DATA,
    PH_MORE,
    PH_DATA2
  } dcsp_phase_t;

  typedef struct packed {
    dcsp_phase_t             phase;
    logic [2:0]              bitcnt;
    logic                    bcast;
    logic                    rd;
    logic                    isreg;
    logic                    borrow;
    logic                    cid_zero;
    logic                    drive;
    logic [BYTE_BITS-1:0]    addr;
    logic [RAM_W-1:0]        data;
    logic [RAM_W-1:0]        tx;
    logic                    reg_tgl;
    logic [ADDR_W-1:0]       reg_addr;
    logic [REG_W-1:0]        reg_data;
    logic                    ram_tgl;
    logic                    ram_write;
    logic [ADDR_W-1:0]       ram_addr;
    logic [RAM_W-1:0]        ram_wdata;
  } dcsp_chan_t;

  typedef struct packed {
    logic                    rst_meta;
    logic                    rst_sync;
    dcsp_chan_t [NCH-1:0]    ch;
  } dcsp_link_t;

  typedef struct packed {
    logic                    valid;
    logic                    write;
    logic [ADDR_W-1:0]       addr;
    logic [RAM_W-1:0]        wdata;
  } dcsp_ram_req_t;

  typedef struct packed {
    logic                    valid;
    logic [ADDR_W-1:0]       addr;
    logic [REG_W-1:0]        data;
  } dcsp_reg_wr_t;

  typedef struct packed {
    logic                    pending;
    logic                    done;
    logic [RAM_W-1:0]        rd_buf;
    dcsp_ram_req_t           req;
    dcsp_reg_wr_t            wr;
  } dcsp_sys_ch_t;

  typedef struct packed {
    dcsp_sys_ch_t [NCH-1:0]  ch;
  } dcsp_sys_t;

  typedef struct packed {
    logic                    meta;
    logic                    sync;
    logic                    prev;
  } dcsp_tsync_t;

endpackage

// ### logic/dcsp_tsync.sv
// toggle to pulse crossing into the system clock
// assumes the toggle source changes at most once per few system cycles
module dcsp_tsync (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // toggle from the link domain
  input  wire logic tgl_in,
  // one-cycle pulse per toggle
  output logic      pulse_out
);

  dcsp_pkg::dcsp_tsync_t q, d;

  always_comb begin
    d      = q;
    d.meta = tgl_in;
    d.sync = q.meta;
    d.prev = q.sync;
    if (srst) begin
      d = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    q <= d;
  end

  assign pulse_out = q.sync ^ q.prev;

endmodule // dcsp_tsync

// ### logic/dcsp_gap.sv
// records that chip select went inactive since the last serial clock rise
// assumes chip select is active low and frames the serial clock
module dcsp_gap (
  // link
  input  wire logic spi_sclk,
  input  wire logic spi_cs_n,
  // high until the first rising edge after chip select returns low
  output logic      gap_q
);

  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      gap_q <= 1'b1;
    end else begin
      gap_q <= 1'b0;
    end
  end

endmodule // dcsp_gap

// ### dv/dcsp_top_monitor.sv
// checker for the serial control port, watching the top module's core-side and serial-out ports
// assumes every output is settled at the system clock's rising edge
module dcsp_top_monitor (
  // clock and reset
  input logic                                        clk_sys,
  input logic                                        srst,
  // serial link
  input logic                                        spi_cs_n,
  input logic                                        spi_sdo,
  input logic                                        spi_sdo_oe,
  // core side
  input logic                                        ram_slot,
  input dcsp_pkg::dcsp_ram_req_t [dcsp_pkg::NCH-1:0] ram_req,
  input logic [dcsp_pkg::NCH-1:0]                    ram_request_pending,
  input logic [dcsp_pkg::NCH-1:0]                    ram_done,
  input dcsp_pkg::dcsp_reg_wr_t [dcsp_pkg::NCH-1:0]  reg_wr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_serve0;
    ram_req[0].valid ##1 (ram_done[0] && !ram_request_pending[0]);
  endsequence
  sequence s_serve1;
    ram_req[1].valid ##1 (ram_done[1] && !ram_request_pending[1]);
  endsequence
  slot_serve0_a: assert property (ram_slot && ram_request_pending[0] && !ram_req[0].valid |=> s_serve0)
    else $error("channel 0 slot not served");
  slot_serve1_a: assert property (ram_slot && ram_request_pending[1] && !ram_req[1].valid |=> s_serve1)
    else $error("channel 1 slot not served");
  req_cause_a: assert property (ram_req[0].valid |-> $past(ram_slot && ram_request_pending[0]))
    else $error("request without slot and pending");
  req_pending_a: assert property (ram_req[1].valid |-> ram_request_pending[1])
    else $error("request issued while not pending");
  pend_clear_a: assert property ($fell(ram_request_pending[0]) |-> ram_done[0])
    else $error("pending cleared without done");
  done_pulse_a: assert property (ram_done[1] |=> !ram_done[1])
    else $error("done longer than one cycle");
  bcast_same_a: assert property (reg_wr[0].valid && reg_wr[1].valid |-> reg_wr[0] == reg_wr[1])
    else $error("broadcast writes differ");
  oe_select_a: assert property (spi_cs_n |-> !spi_sdo_oe)
    else $error("sdo driven while deselected");
  sdo_idle_a: assert property (!spi_sdo_oe |-> !spi_sdo)
    else $error("sdo high while not driving");
endmodule // dcsp_top_monitor

bind dcsp_top dcsp_top_monitor dcsp_top_monitor_inst (.clk_sys(clk_sys), .srst(srst), .spi_cs_n(spi_cs_n),
  .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .ram_slot(ram_slot), .ram_req(ram_req),
  .ram_request_pending(ram_request_pending), .ram_done(ram_done), .reg_wr(reg_wr));

// ### dv/dcsp_host.sv
// host controller model: serial clock within frames, and with select high while the link resets; select per byte or per frame
// assumes a pull-down on sdo, so a released line reads low
module dcsp_host (
  // link towards the device
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  input  logic spi_sdo,
  input  logic spi_sdo_oe,
  input  logic chain_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sdo_line;
  assign sdo_line = spi_sdo_oe ? spi_sdo : 1'b0;
  initial begin
    spi_sclk = 1'b1;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b1;
  end
  // clocks with select high, used only while the link side resets
  task automatic idle(input int n);
    repeat (n) begin
      #32 spi_sclk = 1'b0;
      #32 spi_sclk = 1'b1;
    end
  endtask
  // n bits msb first; from bit dc on sdi toggles as a don't-care; gap raises select after each byte
  task automatic bits(input logic [31:0] v, input int n, input int gap, input int dc,
                      output logic [31:0] r, output logic [31:0] f);
    r = '0;
    f = '0;
    spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_sclk = 1'b0;
      spi_sdi = (i >= dc) ? ~spi_sdi : v[31-i];
      #31 r = {r[30:0], sdo_line};
      f = {f[30:0], chain_data_out};
      #1 spi_sclk = 1'b1;
      #32;
      if (gap != 0 && i % 8 == 7) begin
        spi_cs_n = 1'b1;
        #32 spi_cs_n = (i == n - 1);
      end
    end
    spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;
  endtask
endmodule // dcsp_host

// ### dv/dcsp_top_test.sv
// self-checking bench: register table, chain forwarding, an abandoned frame and the ram pipeline
// assumes the host model and the bound monitor are compiled alongside
module dcsp_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0]  ctl;
    logic [7:0]  adr;
    logic [15:0] dat;
    logic [1:0]  nd;
    logic        gap;
    logic [1:0]  wm;
    logic [15:0] rd;
  } dcsp_row_t;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ram_slot = 1'b0;
  logic slot_en = 1'b0;
  logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe, chain_data_out;
  dcsp_pkg::dcsp_ram_req_t [dcsp_pkg::NCH-1:0] ram_req;
  dcsp_pkg::dcsp_ram_req_t [dcsp_pkg::NCH-1:0] lr = '0;
  logic [dcsp_pkg::NCH-1:0][dcsp_pkg::RAM_W-1:0] ram_rdata = '0;
  logic [dcsp_pkg::NCH-1:0] ram_request_pending, ram_done, seen;
  dcsp_pkg::dcsp_reg_wr_t [dcsp_pkg::NCH-1:0] reg_wr, rl;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  int dn [2] = '{0, 0};
  logic [31:0] r, f;
  logic [3:0] c;
  dcsp_row_t rows [9];
  always #2 clk_sys = ~clk_sys;
  dcsp_top dcsp_top_inst (.clk_sys(clk_sys), .srst(srst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .chain_data_out(chain_data_out),
    .ram_slot(ram_slot), .ram_req(ram_req), .ram_rdata(ram_rdata), .ram_request_pending(ram_request_pending),
    .ram_done(ram_done), .reg_wr(reg_wr));
  dcsp_host dcsp_host_inst (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe), .chain_data_out(chain_data_out));
  function automatic logic [15:0] rdf(input logic [6:0] a);
    return {a, 1'b1, ~a, 1'b0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic xact(input dcsp_row_t w);
    seen = '0;
    dcsp_host_inst.bits({w.ctl, w.adr, w.dat}, 16 + 8 * w.nd, w.gap, w.ctl[6] ? 16 : 32, r, f);
    repeat (12) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 400 && ram_request_pending !== 2'h0; i++) @(posedge clk_sys);
    #1 chk(ram_request_pending, 2'h0);
  endtask
  // core stand-in: slot every 16 cycles, read data follows the request's address while it stands
  always @(posedge clk_sys) begin
    for (int i = 0; i < 2; i++) begin
      if (reg_wr[i].valid) begin
        seen[i] = 1'b1;
        rl[i] = reg_wr[i];
      end
      if (ram_req[i].valid) lr[i] = ram_req[i];
      if (ram_done[i]) dn[i]++;
    end
    cyc++;
    #1 ram_slot = slot_en && cyc % 16 == 0;
    for (int i = 0; i < 2; i++) ram_rdata[i] = rdf(ram_req[i].addr);
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end
  initial begin
    rows = '{'{8'h20, 8'h85, 16'h3c00, 2'h1, 1'h1, 2'h1, 16'h0000}, '{8'h28, 8'h05, 16'ha5ff, 2'h2, 1'h0, 2'h2, 16'h0000},
             '{8'h60, 8'h05, 16'h0000, 2'h1, 1'h1, 2'h0, 16'h003c}, '{8'h68, 8'h05, 16'h0000, 2'h2, 1'h0, 2'h0, 16'ha5a5},
             '{8'h2c, 8'h05, 16'h1100, 2'h1, 1'h1, 2'h0, 16'h0000}, '{8'haa, 8'h07, 16'h7700, 2'h2, 1'h0, 2'h3, 16'h0000},
             '{8'h60, 8'h07, 16'h0000, 2'h2, 1'h0, 2'h0, 16'h7777}, '{8'h64, 8'h05, 16'h0000, 2'h1, 1'h1, 2'h0, 16'h0000},
             '{8'he0, 8'h05, 16'h0000, 2'h1, 1'h1, 2'h0, 16'h0000}};
    // reset spans four serial clocks so the link side sees it
    dcsp_host_inst.idle(4);
    chk({ram_request_pending, ram_done}, 4'h0);
    @(posedge clk_sys);
    #1 srst = 1'b0;
    // the link side's reset synchroniser needs serial clocks to let go
    dcsp_host_inst.idle(3);
    repeat (4) @(posedge clk_sys);
    foreach (rows[k]) begin
      xact(rows[k]);
      chk(seen, rows[k].wm);
      for (int i = 0; i < 2; i++)
        if (rows[k].wm[i]) chk(rl[i], {1'b1, rows[k].adr[6:0], rows[k].dat[15:8]});
      if (rows[k].ctl[6]) chk(rows[k].nd == 2'h1 ? {8'h00, r[7:0]} : r[15:0], rows[k].rd);
      c = {rows[k].ctl[0], rows[k].ctl[1], rows[k].ctl[2], rows[k].ctl[3]} - 4'h2;
      if (rows[k].ctl[7]) chk(8'(f >> (8 * (rows[k].nd + 1))), rows[k].ctl);
      else if (c < 4'he) chk(8'(f >> (8 * (rows[k].nd + 1))), {rows[k].ctl[7:4], c[0], c[1], c[2], c[3]});
    end
    dcsp_host_inst.bits(32'hffffffff, 3, 0, 32, r, f);
    // select stands high a while, so the next frame starts on a seen gap
    repeat (4) @(posedge clk_sys);
    xact('{8'h20, 8'h09, 16'h4200, 2'h1, 1'h1, 2'h0, 16'h0000});
    chk(rl[0], {1'b1, 7'h09, 8'h42});
    xact('{8'h00, 8'h11, 16'h1234, 2'h2, 1'h0, 2'h0, 16'h0000});
    xact('{8'h08, 8'h22, 16'habcd, 2'h2, 1'h0, 2'h0, 16'h0000});
    chk(ram_request_pending, 2'h3);
    slot_en = 1'b1;
    wait_idle();
    chk(lr[0], {1'b1, 1'b1, 7'h11, 16'h1234});
    chk(lr[1], {1'b1, 1'b1, 7'h22, 16'habcd});
    chk(dn[0] * 16 + dn[1], 32'h11);
    slot_en = 1'b0;
    xact('{8'h48, 8'h33, 16'h0000, 2'h2, 1'h0, 2'h0, 16'h0000});
    chk(ram_request_pending, 2'h2);
    slot_en = 1'b1;
    wait_idle();
    chk(lr[1].addr, 7'h33);
    xact('{8'h48, 8'h44, 16'h0000, 2'h2, 1'h0, 2'h0, 16'h0000});
    chk(r[15:0], rdf(7'h33));
    wait_idle();
    summarize();
  end
endmodule // dcsp_top_test
